// ---- pdma_core.sv ----
// four channel dma engine: arbitration, sequencing, addressing, status
// Contract
// - moves data between peripheral data registers and sram.
// - any address of the whole data space is reachable.
// - shared bus arbiter may stall the engine; request holds until grant.
// - four independent channels.
// - each channel serves one selected peripheral, to or from it.
// - timer and external interrupt events can trigger transfers.
// - each channel moves data in one direction only.
// - fixed order by channel number picks a winner; others stay pending.
// - a finished block raises the channel's cpu interrupt unless half_irq is set.
// - interrupt at half block or full block, per channel.
// - post-increment mode steps the sram address per element.
// - no-increment mode keeps the sram address fixed.
// - peripheral indirect mode takes the sram address from the peripheral.
// - element size is byte or word.
// - transfers start by software request or peripheral request.
// - one-shot stops after a block; auto-repeat restarts it.
// - ping-pong alternates two start addresses at each block end.
// - request source selectable from any interrupt source.
// - per channel request select register names the trigger source.
// - per channel transfer count sets block length in elements.
// - shared status reports write and request collisions, last access.
`timescale 1ns/100ps
module pdma_core (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire pdma_pkg::pdma_chan_cfg_t [pdma_pkg::NCH-1:0] i_cfg,
    input wire logic [pdma_pkg::NCH-1:0] i_cfg_wr,
    input wire logic [pdma_pkg::NCH-1:0] i_sw_req,
    input wire logic [pdma_pkg::NSRC-1:0] i_irq_events,
    input wire logic [pdma_pkg::NCH-1:0][pdma_pkg::ADDR_W-1:0] i_pia_addr,
    input wire logic i_coll_clr,
    output pdma_pkg::pdma_bus_req_t o_bus,
    input wire logic i_bus_gnt,
    input wire logic [pdma_pkg::DATA_W-1:0] i_bus_rdata,
    output logic [pdma_pkg::NCH-1:0] o_chan_irq,
    output logic [pdma_pkg::NCH-1:0] o_chan_active,
    output logic [pdma_pkg::NCH-1:0] o_pingpong_status,
    output logic [pdma_pkg::NCH-1:0] o_write_collision_status,
    output logic [pdma_pkg::NCH-1:0] o_request_collision_status,
    output logic [pdma_pkg::CH_W-1:0] o_last_channel,
    output logic [pdma_pkg::ADDR_W-1:0] o_last_address,
    output logic o_busy
);
    pdma_pkg::pdma_state_t q;
    pdma_pkg::pdma_state_t d;
    pdma_pkg::pdma_chan_cfg_t cc;
    logic [pdma_pkg::NCH-1:0] trig;
    logic [pdma_pkg::NCH-1:0] ready_ch;
    logic [pdma_pkg::NCH-1:0] chmask;
    logic [pdma_pkg::CH_W-1:0] win;
    logic win_vld;
    logic [pdma_pkg::ADDR_W-1:0] base;
    logic [pdma_pkg::ADDR_W-1:0] idx32;
    logic [pdma_pkg::ADDR_W-1:0] ofs;
    logic [pdma_pkg::ADDR_W-1:0] ram_addr;
    logic [pdma_pkg::ADDR_W-1:0] per_addr;
    logic [pdma_pkg::ADDR_W-1:0] rd_addr;
    logic [pdma_pkg::ADDR_W-1:0] wr_addr;
    logic [pdma_pkg::BE_W-1:0] rd_be;
    logic [pdma_pkg::BE_W-1:0] wr_be;
    logic [pdma_pkg::DATA_W-1:0] fifo_in_data;
    logic [pdma_pkg::DATA_W-1:0] fifo_out_data;
    logic [pdma_pkg::DATA_W-1:0] wr_data;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic el_done;
    logic blk_last;
    logic blk_half;

    // per channel trigger: selected source event or software kick
    for (genvar c = 0; c < pdma_pkg::NCH; c++) begin : g_trig
        assign trig[c] = q.armed[c] & (i_sw_req[c]
            | i_irq_events[i_cfg[c].channel_request_select
                [pdma_pkg::SEL_W-1:0]]);
    end

    assign ready_ch = q.pend & q.armed;
    assign chmask = pdma_pkg::NCH'(1) << q.ch;

    // fixed priority: scan down so the lowest number is left standing
    always_comb begin
        win = '0;
        win_vld = 1'b0;
        for (int c = pdma_pkg::NCH - 1; c >= 0; c--) begin
            if (ready_ch[c]) begin
                win = pdma_pkg::CH_W'(c);
                win_vld = 1'b1;
            end
        end
    end

    assign cc = i_cfg[q.ch];
    assign base = q.ping[q.ch] ? cc.channel_start_address_b
                               : cc.channel_start_address_a;
    assign idx32 = pdma_pkg::ADDR_W'(q.idx[q.ch]);
    assign ofs = cc.byte_size ? idx32 : (idx32 << 1);

    // sram side address per addressing mode, full data space width
    always_comb begin
        unique case (cc.amode)
            pdma_pkg::PDMA_AM_NOINC: ram_addr = base;
            pdma_pkg::PDMA_AM_PERIPH: ram_addr = i_pia_addr[q.ch];
            default: ram_addr = base + ofs;
        endcase
    end

    assign per_addr = pdma_pkg::ADDR_W'(cc.periph_addr);
    // one way per channel: source and sink fixed by direction
    assign rd_addr = cc.to_periph ? ram_addr : per_addr;
    assign wr_addr = cc.to_periph ? per_addr : ram_addr;

    assign rd_be = !cc.byte_size ? pdma_pkg::BE_WORD
                 : (rd_addr[0] ? pdma_pkg::BE_HI : pdma_pkg::BE_LO);
    assign wr_be = !cc.byte_size ? pdma_pkg::BE_WORD
                 : (wr_addr[0] ? pdma_pkg::BE_HI : pdma_pkg::BE_LO);

    // byte elements travel in the low lane of the fifo
    always_comb begin
        if (!cc.byte_size) begin
            fifo_in_data = i_bus_rdata;
        end else if (rd_addr[0]) begin
            fifo_in_data = {pdma_pkg::BYTE_ZERO,
                            i_bus_rdata[pdma_pkg::DATA_W-1:pdma_pkg::BYTE_W]};
        end else begin
            fifo_in_data = {pdma_pkg::BYTE_ZERO,
                            i_bus_rdata[pdma_pkg::BYTE_W-1:0]};
        end
    end

    assign wr_data = cc.byte_size
        ? {2{fifo_out_data[pdma_pkg::BYTE_W-1:0]}} : fifo_out_data;

    // read data is valid the cycle after the read grant
    assign fifo_in_valid = (q.fsm == pdma_pkg::PDMA_S_RDW);
    assign el_done = (q.fsm == pdma_pkg::PDMA_S_WR) & q.bus.req
                   & i_bus_gnt;
    assign blk_last = (q.idx[q.ch] == cc.channel_transfer_count);
    assign blk_half = (q.idx[q.ch] == (cc.channel_transfer_count >> 1));

    pdma_fifo #(
        .WIDTH(pdma_pkg::DATA_W),
        .DEPTH(pdma_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(el_done),
        .o_out_data(fifo_out_data)
    );

    always_comb begin
        d = q;
        d.irq = '0;
        if (i_coll_clr) begin
            d.wcoll = '0;
            d.rcoll = '0;
        end
        unique case (q.fsm)
            pdma_pkg::PDMA_S_IDLE: begin
                // fifo room stalls the start of a new element
                if (win_vld && fifo_in_ready) begin
                    d.ch = win;
                    d.fsm = pdma_pkg::PDMA_S_RD;
                end
            end
            pdma_pkg::PDMA_S_RD: begin
                if (!q.bus.req) begin
                    d.bus.req = 1'b1;
                    d.bus.we = 1'b0;
                    d.bus.addr = rd_addr;
                    d.bus.be = rd_be;
                end else if (i_bus_gnt) begin
                    d.bus.req = 1'b0;
                    d.last_addr = q.bus.addr;
                    d.last_ch = q.ch;
                    d.fsm = pdma_pkg::PDMA_S_RDW;
                end
            end
            pdma_pkg::PDMA_S_RDW: begin
                d.fsm = pdma_pkg::PDMA_S_WR;
            end
            pdma_pkg::PDMA_S_WR: begin
                if (!q.bus.req && fifo_out_valid) begin
                    d.bus.req = 1'b1;
                    d.bus.we = 1'b1;
                    d.bus.addr = wr_addr;
                    d.bus.be = wr_be;
                    d.bus.wdata = wr_data;
                end else if (q.bus.req && i_bus_gnt) begin
                    d.bus.req = 1'b0;
                    d.last_addr = q.bus.addr;
                    d.last_ch = q.ch;
                    d.fsm = pdma_pkg::PDMA_S_IDLE;
                    d.pend[q.ch] = 1'b0;
                    if (cc.half_irq ? blk_half : blk_last) begin
                        d.irq[q.ch] = 1'b1;
                    end
                    if (blk_last) begin
                        d.idx[q.ch] = '0;
                        if (cc.ping_pong) begin
                            d.ping[q.ch] = !q.ping[q.ch];
                        end
                        if (!cc.auto_repeat) begin
                            d.armed[q.ch] = 1'b0;
                        end
                    end else begin
                        d.idx[q.ch] = q.idx[q.ch] + 1'b1;
                    end
                end
            end
        endcase
        for (int c = 0; c < pdma_pkg::NCH; c++) begin
            d.en_prev[c] = i_cfg[c].enable;
            if (!i_cfg[c].enable) begin
                d.armed[c] = 1'b0;
                d.pend[c] = 1'b0;
            end else if (!q.en_prev[c]) begin
                d.armed[c] = 1'b1;
                d.idx[c] = '0;
                d.ping[c] = 1'b0;
            end
            // a new request wins over the clear of the same cycle
            if (trig[c]) begin
                d.pend[c] = 1'b1;
                if (q.pend[c] && !(el_done && q.ch == c)) begin
                    d.rcoll[c] = 1'b1;
                end
            end
            if (i_cfg_wr[c] && q.armed[c] && q.fsm != pdma_pkg::PDMA_S_IDLE
                    && q.ch == c) begin
                d.wcoll[c] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            q <= '0;
            q.fsm <= pdma_pkg::PDMA_S_IDLE;
        end else begin
            q <= d;
        end
    end

    assign o_bus = q.bus;
    assign o_chan_irq = q.irq;
    assign o_chan_active = q.armed;
    assign o_pingpong_status = q.ping;
    assign o_write_collision_status = q.wcoll;
    assign o_request_collision_status = q.rcoll;
    assign o_last_channel = q.last_ch;
    assign o_last_address = q.last_addr;
    assign o_busy = (q.fsm != pdma_pkg::PDMA_S_IDLE);

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_rd_grant;
        q.fsm == pdma_pkg::PDMA_S_RD && q.bus.req && i_bus_gnt;
    endsequence

    sequence s_push_then_write;
        fifo_in_valid && fifo_in_ready ##1 q.fsm == pdma_pkg::PDMA_S_WR;
    endsequence

    property p_hold_req;
        q.bus.req && !i_bus_gnt |=> q.bus.req && $stable(q.bus.addr);
    endproperty
    a_hold_req: assert property (p_hold_req)
        else $error("bus request dropped or moved before grant");

    property p_rd_push;
        s_rd_grant |-> !q.bus.we ##1 s_push_then_write;
    endproperty
    a_rd_push: assert property (p_rd_push)
        else $error("read grant not followed by fifo push and write");

    property p_one_way;
        q.fsm == pdma_pkg::PDMA_S_WR && q.bus.req
            |-> q.bus.we && q.bus.addr == wr_addr;
    endproperty
    a_one_way: assert property (p_one_way)
        else $error("write phase not aimed at the sink");

    property p_prio;
        q.fsm == pdma_pkg::PDMA_S_IDLE && ready_ch[0] && fifo_in_ready
            |=> q.ch == '0 && q.fsm == pdma_pkg::PDMA_S_RD;
    endproperty
    a_prio: assert property (p_prio)
        else $error("channel zero did not win");

    property p_pend_kept;
        q.pend[3] && q.armed[3] && i_cfg[3].enable
            && q.fsm != pdma_pkg::PDMA_S_IDLE && q.ch != 2'h3
            |=> q.pend[3];
    endproperty
    a_pend_kept: assert property (p_pend_kept)
        else $error("losing channel lost its request");

    property p_byte_be;
        q.bus.req && cc.byte_size |-> q.bus.be != pdma_pkg::BE_WORD;
    endproperty
    a_byte_be: assert property (p_byte_be)
        else $error("byte element used both lanes");

    property p_noinc;
        q.fsm == pdma_pkg::PDMA_S_RD && q.bus.req && cc.to_periph
            && cc.amode == pdma_pkg::PDMA_AM_NOINC |-> q.bus.addr == base;
    endproperty
    a_noinc: assert property (p_noinc)
        else $error("fixed address mode moved the address");

    property p_postinc;
        q.fsm == pdma_pkg::PDMA_S_RD && q.bus.req && cc.to_periph
            && cc.amode == pdma_pkg::PDMA_AM_POSTINC
            |-> q.bus.addr == base + ofs;
    endproperty
    a_postinc: assert property (p_postinc)
        else $error("post increment address wrong");

    property p_irq_full;
        el_done && !cc.half_irq && blk_last |=> (o_chan_irq & chmask) != '0;
    endproperty
    a_irq_full: assert property (p_irq_full)
        else $error("no interrupt at block end");

    property p_irq_half;
        el_done && cc.half_irq && blk_half |=> (o_chan_irq & chmask) != '0;
    endproperty
    a_irq_half: assert property (p_irq_half)
        else $error("no interrupt at half block");

    property p_ping;
        el_done && blk_last && cc.ping_pong && i_cfg[q.ch].enable
            |=> (q.ping ^ $past(q.ping)) == chmask;
    endproperty
    a_ping: assert property (p_ping)
        else $error("ping-pong did not switch buffers");

    property p_oneshot;
        el_done && blk_last && !cc.auto_repeat |=> (q.armed & chmask) == '0;
    endproperty
    a_oneshot: assert property (p_oneshot)
        else $error("one-shot channel still armed");

    property p_sw_start;
        i_sw_req[0] && q.armed[0] && i_cfg[0].enable |=> q.pend[0];
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software request not taken");

    property p_rcoll;
        trig[3] && q.pend[3] && !(el_done && q.ch == 2'h3)
            |=> o_request_collision_status[3];
    endproperty
    a_rcoll: assert property (p_rcoll)
        else $error("request collision not flagged");
endmodule

// ---- pdma_pkg.sv ----
// shared constants and types of the four channel peripheral dma
package pdma_pkg;
    localparam int NCH = 4;
    localparam int CH_W = 2;
    localparam int CNT_W = 14;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam int PADDR_W = 16;
    localparam int REQ_W = 16;
    localparam int SEL_W = 8;
    localparam int NSRC = 256;
    localparam int FIFO_DEPTH = 8;
    localparam int BE_W = 2;
    localparam int BYTE_W = 8;
    localparam logic [BE_W-1:0] BE_LO = 2'h1;
    localparam logic [BE_W-1:0] BE_HI = 2'h2;
    localparam logic [BE_W-1:0] BE_WORD = 2'h3;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        PDMA_AM_POSTINC = 2'h0,
        PDMA_AM_NOINC = 2'h1,
        PDMA_AM_PERIPH = 2'h2
    } pdma_amode_t;

    typedef enum logic [3:0] {
        PDMA_S_IDLE = 4'h1,
        PDMA_S_RD = 4'h2,
        PDMA_S_RDW = 4'h4,
        PDMA_S_WR = 4'h8
    } pdma_fsm_t;

    // one channel's configuration
    typedef struct packed {
        logic enable;
        logic to_periph;
        logic byte_size;
        pdma_amode_t amode;
        logic auto_repeat;
        logic ping_pong;
        logic half_irq;
        logic [REQ_W-1:0] channel_request_select;
        logic [ADDR_W-1:0] channel_start_address_a;
        logic [ADDR_W-1:0] channel_start_address_b;
        logic [PADDR_W-1:0] periph_addr;
        logic [CNT_W-1:0] channel_transfer_count;
    } pdma_chan_cfg_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BE_W-1:0] be;
    } pdma_bus_req_t;

    typedef struct packed {
        pdma_fsm_t fsm;
        logic [CH_W-1:0] ch;
        logic [NCH-1:0] pend;
        logic [NCH-1:0] armed;
        logic [NCH-1:0] en_prev;
        logic [NCH-1:0] ping;
        logic [NCH-1:0][CNT_W-1:0] idx;
        logic [NCH-1:0] wcoll;
        logic [NCH-1:0] rcoll;
        logic [NCH-1:0] irq;
        logic [ADDR_W-1:0] last_addr;
        logic [CH_W-1:0] last_ch;
        pdma_bus_req_t bus;
    } pdma_state_t;
endpackage

// ---- pdma_fifo.sv ----
// element fifo between the read and write phases
`timescale 1ns/100ps
module pdma_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } pdma_fifo_state_t;

    pdma_fifo_state_t q;
    pdma_fifo_state_t d;
    logic push;
    logic pop;

    assign o_in_ready = (q.cnt != FULL);
    assign o_out_valid = (q.cnt != '0);
    assign o_out_data = q.mem[q.rp];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = i_in_data;
            d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
        end
        unique case ({push, pop})
            2'h2: d.cnt = q.cnt + 1'b1;
            2'h1: d.cnt = q.cnt - 1'b1;
            default: d.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// ---- pdma_mem_model.sv ----
// sram and bus arbiter model facing the dma engine
`timescale 1ns/100ps
module pdma_mem_model (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire pdma_pkg::pdma_bus_req_t i_bus,
    input wire logic [3:0] i_wait,
    output logic o_bus_gnt,
    output logic [pdma_pkg::DATA_W-1:0] o_bus_rdata
);
    logic [3:0] cnt_q;
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            cnt_q <= 4'h0;
            o_bus_gnt <= 1'b0;
            o_bus_rdata <= 16'h0000;
        end else begin
            // grant after i_wait cycles, as a busy cpu would
            if (i_bus.req && !o_bus_gnt && cnt_q == i_wait) begin
                o_bus_gnt <= 1'b1;
                cnt_q <= 4'h0;
            end else begin
                o_bus_gnt <= 1'b0;
                if (i_bus.req && !o_bus_gnt)
                    cnt_q <= cnt_q + 4'h1;
            end
            // data valid only the cycle after a read grant
            if (i_bus.req && o_bus_gnt && !i_bus.we)
                o_bus_rdata <= i_bus.addr[15:0] ^ 16'ha5c3;
            else
                o_bus_rdata <= ~o_bus_rdata;
        end
    end
endmodule

// ---- four_channel_peripheral_dma_test.sv ----
// self-checking bench of the four channel dma engine
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module four_channel_peripheral_dma_test;
    typedef struct packed {
        logic [1:0] ch; logic tp; logic bs; pdma_pkg::pdma_amode_t am;
        logic ev; logic [7:0] src; logic [3:0] wt; logic [31:0] sa;
        logic [15:0] pa; logic [31:0] pia; logic [31:0] ra;
        logic [31:0] wa; logic [1:0] be;
    } pdma_row_t;
    pdma_row_t rows [4] = '{
        '{2'h0, 1'b0, 1'b0, pdma_pkg::PDMA_AM_POSTINC, 1'b0, 8'h00, 4'h0,
          32'h1000, 16'h0300, 32'h0, 32'h0300, 32'h1000, 2'h3},
        '{2'h1, 1'b1, 1'b0, pdma_pkg::PDMA_AM_NOINC, 1'b1, 8'h0c, 4'h2,
          32'h2000, 16'h0224, 32'h0, 32'h2000, 32'h0224, 2'h3},
        '{2'h2, 1'b0, 1'b1, pdma_pkg::PDMA_AM_POSTINC, 1'b1, 8'h0b, 4'h1,
          32'h3001, 16'h0226, 32'h0, 32'h0226, 32'h3001, 2'h2},
        '{2'h3, 1'b0, 1'b0, pdma_pkg::PDMA_AM_PERIPH, 1'b1, 8'h07, 4'h3,
          32'h4000, 16'h0300, 32'h804000, 32'h0300, 32'h804000, 2'h3}};
    logic clk, rst_n, coll_clr, gnt, busy;
    pdma_pkg::pdma_chan_cfg_t [3:0] cfg;
    logic [3:0] sw_req, cfg_wr, irq, act, pps, wcol, rcol, wt;
    logic [255:0] evt;
    logic [3:0][31:0] pia;
    pdma_pkg::pdma_bus_req_t bus;
    logic [15:0] rdata, wd;
    logic [1:0] lch, be;
    logic [31:0] laddr, ra, wa;
    pdma_pkg::pdma_chan_cfg_t c;
    int mismatches = 0;
    int n_compared = 0;

    pdma_core DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_cfg(cfg),
        .i_cfg_wr(cfg_wr), .i_sw_req(sw_req), .i_irq_events(evt),
        .i_pia_addr(pia), .i_coll_clr(coll_clr), .o_bus(bus),
        .i_bus_gnt(gnt), .i_bus_rdata(rdata), .o_chan_irq(irq),
        .o_chan_active(act), .o_pingpong_status(pps),
        .o_write_collision_status(wcol),
        .o_request_collision_status(rcol), .o_last_channel(lch),
        .o_last_address(laddr), .o_busy(busy));
    pdma_mem_model u_mem (.i_ref_clk(clk), .i_reset_n(rst_n), .i_bus(bus),
        .i_wait(wt), .o_bus_gnt(gnt), .o_bus_rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic pdma_pkg::pdma_chan_cfg_t mk(logic tp, logic bs,
            pdma_pkg::pdma_amode_t am, logic [31:0] sa, logic [15:0] pa,
            logic [7:0] src);
        mk = '0;
        mk.to_periph = tp;
        mk.byte_size = bs;
        mk.amode = am;
        mk.channel_start_address_a = sa;
        mk.channel_start_address_b = 32'h5000;
        mk.periph_addr = pa;
        mk.channel_request_select = {8'h00, src};
    endfunction

    task automatic arm(input int ch, input pdma_pkg::pdma_chan_cfg_t v);
        v.enable = 1'b0;
        cfg[ch] <= v;
        @(posedge clk);
        v.enable = 1'b1;
        cfg[ch] <= v;
        repeat (2) @(posedge clk);
    endtask

    // bounded wait for a granted access of the given direction
    task automatic wait_acc(input logic we, output logic [31:0] a);
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (bus.req === 1'b1 && gnt === 1'b1 && bus.we === we)
                break;
        end
        if (i == 200) begin
            mismatches++;
            give_verdict();
        end
        a = bus.addr;
        wd = bus.wdata;
        be = bus.be;
    endtask

    task automatic elem(input int ch, input logic ev);
        if (ev)
            evt[cfg[ch].channel_request_select[7:0]] <= 1'b1;
        else
            sw_req[ch] <= 1'b1;
        @(posedge clk);
        evt <= '0;
        sw_req <= '0;
        wait_acc(1'b0, ra);
        wait_acc(1'b1, wa);
    endtask

    initial begin
        rst_n = 1'b0;
        cfg = '0;
        cfg_wr = '0;
        sw_req = '0;
        evt = '0;
        pia = '0;
        coll_clr = 1'b0;
        wt = 4'h0;
        repeat (4) @(posedge clk);
        `CHK({bus.req, busy, act}, 6'h00)
        rst_n <= 1'b1;
        @(posedge clk);
        for (int r = 0; r < 4; r++) begin
            c = mk(rows[r].tp, rows[r].bs, rows[r].am, rows[r].sa,
                rows[r].pa, rows[r].src);
            pia[rows[r].ch] <= rows[r].pia;
            wt <= rows[r].wt;
            arm(rows[r].ch, c);
            `CHK(act[rows[r].ch], 1'b1)
            elem(rows[r].ch, rows[r].ev);
            `CHK(ra, rows[r].ra)
            `CHK(wa, rows[r].wa)
            `CHK(be, rows[r].be)
            if (!rows[r].bs)
                `CHK(wd, rows[r].ra[15:0] ^ 16'ha5c3)
            else
                `CHK(wd, {2{rows[r].ra[7:0] ^ 8'hc3}})
            @(posedge clk);
            `CHK(irq[rows[r].ch], 1'b1)
            @(posedge clk);
            `CHK(act[rows[r].ch], 1'b0)
            `CHK({lch, laddr}, {rows[r].ch, rows[r].wa})
        end
        wt <= 4'h0;
        c = mk(1'b0, 1'b0, pdma_pkg::PDMA_AM_POSTINC, 32'h1000, 16'h0300,
            8'h00);
        c.channel_transfer_count = 14'h1;
        c.auto_repeat = 1'b1;
        c.ping_pong = 1'b1;
        arm(0, c);
        elem(0, 1'b0);
        @(posedge clk);
        `CHK(irq[0], 1'b0)
        elem(0, 1'b0);
        `CHK(wa, 32'h1002)
        @(posedge clk);
        `CHK({irq[0], act[0], pps[0]}, 3'h7)
        elem(0, 1'b0);
        `CHK(wa, 32'h5000)
        c = mk(1'b0, 1'b0, pdma_pkg::PDMA_AM_NOINC, 32'h6000, 16'h0300,
            8'h00);
        c.channel_transfer_count = 14'h3;
        c.half_irq = 1'b1;
        arm(1, c);
        elem(1, 1'b0);
        @(posedge clk);
        `CHK(irq[1], 1'b0)
        elem(1, 1'b0);
        `CHK(wa, 32'h6000)
        @(posedge clk);
        `CHK(irq[1], 1'b1)
        // read and write of one peripheral use two channels
        c = mk(1'b1, 1'b0, pdma_pkg::PDMA_AM_POSTINC, 32'h7000, 16'h0300,
            8'h00);
        arm(3, c);
        sw_req <= 4'ha;
        @(posedge clk);
        sw_req <= 4'h8;
        @(posedge clk);
        sw_req <= 4'h0;
        wait_acc(1'b1, wa);
        `CHK(wa, 32'h6000)
        // config touch while channel three is being served
        @(posedge clk);
        cfg_wr <= 4'h8;
        @(posedge clk);
        cfg_wr <= 4'h0;
        wait_acc(1'b1, wa);
        `CHK(wa, 32'h0300)
        `CHK({wcol, rcol}, 8'h88)
        coll_clr <= 1'b1;
        @(posedge clk);
        coll_clr <= 1'b0;
        @(posedge clk);
        `CHK({wcol, rcol}, 8'h00)
        `CHK(act, 4'h3)
        // reset in mid-run drops arming and buffer selection
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK({bus.req, busy, act, pps, irq}, 14'h0000)
        give_verdict();
    end
endmodule
